// ---- autorange_pkg.sv ----
/*
  Constants shared by the seamless autorange blend controller.
  Assumes a 100 MHz pclk and range samples in a common scale of 1 uV per LSB.
*/
package autorange_pkg;
  // Sample and weight widths
  localparam int SAMPLE_W = 32;
  localparam int WT_W = 9;
  localparam logic [8:0] WT_FULL = 9'h100;  // Weight of 1.0
  localparam int WT_SHIFT = 8;
  localparam int CNT_W = 20;
  // Timing in printed units, then derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int T_SHUT_US = 200;
  localparam int T_SETTLE_MS = 10;
  localparam int SHUT_CYC = T_SHUT_US * CLK_MHZ;
  localparam int SETTLE_CYC = T_SETTLE_MS * 1000 * CLK_MHZ;
  // Magnitude thresholds in uV
  localparam logic [31:0] TH_LOW_UV = 32'h000ecd10;   // 0.97 V, 1 V to 10 V blend start
  localparam logic [31:0] TH_MID_UV = 32'h00989680;   // 10 V, 10 V to 100 V blend start
  localparam logic [31:0] TH_HIGH_UV = 32'h05c81a40;  // 97 V, 100 V to 1000 V blend start
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STEP = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_WEIGHT = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN = 8'h18;
  // Field positions and reset values
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_RANGE_LSB = 1;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  localparam logic [8:0] STEP_RESET = 9'h010;
  localparam int IRQ_W = 3;
  localparam int IRQ_OVL = 0;
  localparam int IRQ_RESTORE = 1;
  localparam int IRQ_INVALID = 2;
  localparam int WEIGHT_W1_LSB = 10;
  localparam int WEIGHT_W2_LSB = 20;
  // Manually selectable ranges
  typedef enum logic [1:0] {
    RANGE_1V = 2'b00,
    RANGE_10V = 2'b01,
    RANGE_100V = 2'b10,
    RANGE_1000V = 2'b11
  } range_e;
  // Direct input path states
  typedef enum logic [1:0] {
    DP_ON = 2'b00,
    DP_SHUT = 2'b01,
    DP_WAIT = 2'b10
  } dp_e;
endpackage

// ---- range_blend.sv ----
/*
  One cross-fade stage: y = lo + (hi - lo) * w / 256, registered on en.
  Assumes w never exceeds 256, so y stays between lo and hi.
*/
`timescale 1ns/1ps
module range_blend (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic signed [31:0] lo,
  input wire logic signed [31:0] hi,
  input wire logic [8:0] w,
  output logic signed [31:0] y
);
  logic signed [32:0] diff;   // Span between the two ranges
  logic signed [42:0] prod;   // Span scaled by the weight
  logic signed [31:0] y_d;    // Next output

  // Weighted mix of the two samples
  always_comb
  begin
    diff = 33'(hi) - 33'(lo);
    prod = 43'(diff) * 43'(signed'({1'b0, w}));
    y_d = lo + 32'(prod >>> autorange_pkg::WT_SHIFT);
  end

  // Output register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      y <= 32'h00000000;
    else if (en)
      y <= y_d;
  end
endmodule

// ---- autorange_ctrl.sv ----
/*
  Seamless autorange blend controller with APB registers and one interrupt.
  Assumes four range converters deliver aligned samples with in_valid, and an
  analog detector raises ovl_det above 11 V.
*/
`timescale 1ns/1ps
module autorange_ctrl #(
  parameter int SHUT_CYC = autorange_pkg::SHUT_CYC,
  parameter int SETTLE_CYC = autorange_pkg::SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic signed [31:0] smp_1v,
  input wire logic signed [31:0] smp_10v,
  input wire logic signed [31:0] smp_100v,
  input wire logic signed [31:0] smp_1000v,
  input wire logic ovl_det,
  output logic direct_en,
  output logic out_valid,
  output logic signed [31:0] out_sample,
  output logic out_ok,
  output logic irq
);
  // Magnitude of a signed sample
  function automatic logic [31:0] mag(input logic signed [31:0] s);
    mag = s[31] ? 32'(-s) : 32'(s);
  endfunction

  // Saturating linear weight step
  function automatic logic [8:0] ramp(input logic [8:0] w, input logic [8:0] step, input logic up);
    logic [9:0] t;
    t = 10'h000;
    if (up)
    begin
      t = 10'(w) + 10'(step);
      ramp = (t > 10'(autorange_pkg::WT_FULL)) ? autorange_pkg::WT_FULL : t[8:0];
    end
    else
      ramp = (step > w) ? 9'h000 : w - step;
  endfunction

  // Register state
  logic [2:0] ctrl_q, ctrl_d;             // Auto enable and manual range
  logic [8:0] step_q, step_d;             // Weight increment per sample
  logic [2:0] irq_stat_q, irq_stat_d;     // Sticky events
  logic [2:0] irq_en_q, irq_en_d;         // Event enables
  logic [31:0] prdata_d;                  // Read data captured in setup
  logic [2:0] irq_set;                    // Events this cycle
  logic wr_en, rd_setup, hit;
  // Blend weights, one per boundary
  logic [8:0] w0_q, w0_d, w1_q, w1_d, w2_q, w2_d;
  logic [8:0] w0_eff, w1_eff, w2_eff;
  // Direct path supervision
  autorange_pkg::dp_e dp_q, dp_d;
  logic [19:0] cnt_q, cnt_d;
  logic excursion, auto_en, man_high;
  autorange_pkg::range_e man_range;
  // Pipeline between the two blend stages
  logic v1_q, v1_d, ok1_q, ok1_d, ok_now;
  logic [8:0] w1s_q, w1s_d;
  logic signed [31:0] low_pair, high_pair;

  assign auto_en = ctrl_q[autorange_pkg::CTRL_AUTO];
  assign man_range = autorange_pkg::range_e'(ctrl_q[2:1]);
  assign man_high = !auto_en && man_range[1];
  assign pready = 1'b1;

  // APB decode and register next values
  always_comb
  begin
    hit = (paddr == autorange_pkg::REG_CTRL) || (paddr == autorange_pkg::REG_STEP) ||
          (paddr == autorange_pkg::REG_STATUS) || (paddr == autorange_pkg::REG_WEIGHT) ||
          (paddr == autorange_pkg::REG_IRQ_STAT) || (paddr == autorange_pkg::REG_IRQ_CLR) ||
          (paddr == autorange_pkg::REG_IRQ_EN);
    pslverr = psel && penable && !hit;
    wr_en = psel && penable && pwrite && hit;
    rd_setup = psel && !penable && !pwrite;
    ctrl_d = ctrl_q;
    step_d = step_q;
    irq_en_d = irq_en_q;
    irq_stat_d = irq_stat_q;
    prdata_d = prdata;
    if (wr_en && paddr == autorange_pkg::REG_CTRL)
      ctrl_d = pwdata[2:0];
    if (wr_en && paddr == autorange_pkg::REG_STEP)
      step_d = pwdata[8:0];
    if (wr_en && paddr == autorange_pkg::REG_IRQ_EN)
      irq_en_d = pwdata[2:0];
    // Clear first, then set so a new event wins
    if (wr_en && paddr == autorange_pkg::REG_IRQ_CLR)
      irq_stat_d = irq_stat_d & ~pwdata[2:0];
    irq_stat_d = irq_stat_d | irq_set;
    if (rd_setup)
    begin
      case (paddr)
        autorange_pkg::REG_CTRL: prdata_d = {29'h0, ctrl_q};
        autorange_pkg::REG_STEP: prdata_d = {23'h0, step_q};
        autorange_pkg::REG_STATUS: prdata_d = {28'h0, ok_now, dp_q, direct_en};
        autorange_pkg::REG_WEIGHT: prdata_d = {3'h0, w2_q, 1'b0, w1_q, 1'b0, w0_q};
        autorange_pkg::REG_IRQ_STAT: prdata_d = {29'h0, irq_stat_q};
        autorange_pkg::REG_IRQ_EN: prdata_d = {29'h0, irq_en_q};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= autorange_pkg::CTRL_RESET;
      step_q <= autorange_pkg::STEP_RESET;
      irq_en_q <= 3'h0;
      irq_stat_q <= 3'h0;
      prdata <= 32'h00000000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      step_q <= step_d;
      irq_en_q <= irq_en_d;
      irq_stat_q <= irq_stat_d;
      prdata <= prdata_d;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Direct path supervision: on, shutting down, settling
  always_comb
  begin
    dp_d = dp_q;
    cnt_d = cnt_q;
    irq_set = 3'h0;
    excursion = ovl_det || (in_valid && mag(smp_100v) >= autorange_pkg::TH_MID_UV);
    case (dp_q)
      autorange_pkg::DP_ON:
      begin
        if (ovl_det)
        begin
          dp_d = autorange_pkg::DP_SHUT;
          cnt_d = 20'h00000;
          irq_set[autorange_pkg::IRQ_OVL] = 1'b1;
        end
      end
      autorange_pkg::DP_SHUT:
      begin
        // Fixed shutdown allowance before settling starts
        if (cnt_q == 20'(SHUT_CYC - 1))
        begin
          dp_d = autorange_pkg::DP_WAIT;
          cnt_d = 20'h00000;
        end
        else
          cnt_d = cnt_q + 20'h00001;
      end
      autorange_pkg::DP_WAIT:
      begin
        // Any excursion restarts the settle time
        if (excursion)
          cnt_d = 20'h00000;
        else if (cnt_q == 20'(SETTLE_CYC - 1))
        begin
          dp_d = autorange_pkg::DP_ON;
          cnt_d = 20'h00000;
          irq_set[autorange_pkg::IRQ_RESTORE] = 1'b1;
        end
        else
          cnt_d = cnt_q + 20'h00001;
      end
      default:
      begin
        dp_d = autorange_pkg::DP_ON;
        cnt_d = 20'h00000;
      end
    endcase
    // Manual low range sample flagged invalid while path is down
    irq_set[autorange_pkg::IRQ_INVALID] = in_valid && !ok_now;
  end

  // Direct path flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dp_q <= autorange_pkg::DP_ON;
      cnt_q <= 20'h00000;
    end
    else
    begin
      dp_q <= dp_d;
      cnt_q <= cnt_d;
    end
  end

  // Manual high ranges keep the path off; low ones follow supervision
  assign direct_en = (dp_q == autorange_pkg::DP_ON) && !man_high;
  assign ok_now = auto_en || man_high || (dp_q == autorange_pkg::DP_ON);

  // Weight ramps, one per boundary, no hysteresis band
  always_comb
  begin
    w0_d = w0_q;
    w1_d = w1_q;
    w2_d = w2_q;
    if (in_valid)
    begin
      w0_d = ramp(w0_q, step_q, mag(smp_10v) >= autorange_pkg::TH_LOW_UV);
      w1_d = ramp(w1_q, step_q, mag(smp_100v) >= autorange_pkg::TH_MID_UV);
      w2_d = ramp(w2_q, step_q, mag(smp_1000v) >= autorange_pkg::TH_HIGH_UV);
    end
  end

  // Weight flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      w0_q <= 9'h000;
      w1_q <= 9'h000;
      w2_q <= 9'h000;
    end
    else
    begin
      w0_q <= w0_d;
      w1_q <= w1_d;
      w2_q <= w2_d;
    end
  end

  // Weights applied to the current sample
  always_comb
  begin
    w0_eff = w0_q;
    w2_eff = w2_q;
    // Auto: low pair unusable whenever the direct path is not on
    w1_eff = (dp_q != autorange_pkg::DP_ON) ? autorange_pkg::WT_FULL : w1_q;
    if (!auto_en)
    begin
      // Manual: pick one converter with weights at the ends
      w0_eff = (man_range == autorange_pkg::RANGE_1V) ? 9'h000 : autorange_pkg::WT_FULL;
      w1_eff = man_range[1] ? autorange_pkg::WT_FULL : 9'h000;
      w2_eff = (man_range == autorange_pkg::RANGE_1000V) ? autorange_pkg::WT_FULL : 9'h000;
    end
  end

  // Both pairs blended on every sample, then the pair results
  range_blend u_low (.pclk(pclk), .presetn(presetn), .en(in_valid), .lo(smp_1v),
                     .hi(smp_10v), .w(w0_eff), .y(low_pair));
  range_blend u_high (.pclk(pclk), .presetn(presetn), .en(in_valid), .lo(smp_100v),
                      .hi(smp_1000v), .w(w2_eff), .y(high_pair));
  range_blend u_mid (.pclk(pclk), .presetn(presetn), .en(v1_q), .lo(low_pair),
                     .hi(high_pair), .w(w1s_q), .y(out_sample));

  // Stage one side data
  always_comb
  begin
    v1_d = in_valid;
    w1s_d = in_valid ? w1_eff : w1s_q;
    ok1_d = in_valid ? ok_now : ok1_q;
  end

  // Pipeline flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      v1_q <= 1'b0;
      w1s_q <= 9'h000;
      ok1_q <= 1'b0;
      out_valid <= 1'b0;
      out_ok <= 1'b0;
    end
    else
    begin
      v1_q <= v1_d;
      w1s_q <= w1s_d;
      ok1_q <= ok1_d;
      out_valid <= v1_q;
      out_ok <= v1_q ? ok1_q : out_ok;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_settled;
    (dp_q == autorange_pkg::DP_WAIT) && cnt_q == 20'(SETTLE_CYC - 1) && !excursion;
  endsequence

  chk_weight_sat: assert property (w0_q <= autorange_pkg::WT_FULL && w1_q <= autorange_pkg::WT_FULL
    && w2_q <= autorange_pkg::WT_FULL)
    else $error("blend weight above full scale");
  chk_ramp_up: assert property (in_valid && mag(smp_10v) >= autorange_pkg::TH_LOW_UV
    && 10'(w0_q) + 10'(step_q) <= 10'(autorange_pkg::WT_FULL) |=> w0_q == $past(w0_q) + $past(step_q))
    else $error("weight did not rise by step");
  chk_ramp_down: assert property (in_valid && mag(smp_10v) < autorange_pkg::TH_LOW_UV
    && w0_q >= step_q |=> w0_q == $past(w0_q) - $past(step_q))
    else $error("weight did not fall by step");
  chk_high_start: assert property (in_valid && mag(smp_1000v) >= autorange_pkg::TH_HIGH_UV
    && w2_q < autorange_pkg::WT_FULL && step_q != 9'h000 |=> w2_q > $past(w2_q))
    else $error("high boundary blend did not start");
  chk_ovl_off: assert property (ovl_det && dp_q == autorange_pkg::DP_ON |=> !direct_en
    && dp_q == autorange_pkg::DP_SHUT ##1 cnt_q == 20'h00001)
    else $error("overload did not shut direct path");
  chk_shut_time: assert property (dp_q == autorange_pkg::DP_SHUT && cnt_q == 20'(SHUT_CYC - 1)
    |=> dp_q == autorange_pkg::DP_WAIT && cnt_q == 20'h00000)
    else $error("shutdown allowance wrong");
  chk_wait_restart: assert property (dp_q == autorange_pkg::DP_WAIT && excursion
    |=> cnt_q == 20'h00000 && dp_q == autorange_pkg::DP_WAIT)
    else $error("excursion did not restart settle");
  chk_reactivate: assert property (s_settled |=> dp_q == autorange_pkg::DP_ON && irq_stat_q[1])
    else $error("path not restored after settle");
  chk_manual_pick: assert property (!auto_en && man_range == autorange_pkg::RANGE_10V && in_valid
    |=> low_pair == $past(smp_10v))
    else $error("manual range not taken alone");
  chk_manual_high: assert property (man_high |-> !direct_en && w1_eff == autorange_pkg::WT_FULL)
    else $error("direct path on in manual high range");
  chk_manual_ovl: assert property (!auto_en && !man_high && ovl_det |=> !direct_en ##1 !direct_en)
    else $error("manual overload kept path on");
  chk_manual_valid: assert property (!auto_en && !man_high && dp_q != autorange_pkg::DP_ON && in_valid
    |=> ##1 out_valid && !out_ok)
    else $error("sample marked valid during recovery");
endmodule

// ---- range_adc_model.sv ----
/*
  Four parallel range converters and the analog overload detector.
  Assumes 1 uV per LSB and one conversion every fourth pclk cycle while run is high.
*/
`timescale 1ns/1ps
module range_adc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic direct_en,
  input wire logic signed [31:0] volt_uv,
  output logic in_valid,
  output logic ovl_det,
  output logic signed [31:0] smp_1v,
  output logic signed [31:0] smp_10v,
  output logic signed [31:0] smp_100v,
  output logic signed [31:0] smp_1000v
);
  logic [1:0] cnt_q; // Conversion cadence
  logic signed [31:0] v_q; // Input registered every cycle, one cycle behind volt_uv
  // Clip at the range's full scale, drop bits below its resolution
  function automatic logic signed [31:0] conv(input logic signed [31:0] x, input logic signed [31:0] fs,
    input logic [31:0] m);
    logic signed [31:0] c;
    c = (x > fs) ? fs : ((x < -fs) ? -fs : x);
    return c & m;
  endfunction
  // Strobe all four results together
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 2'h0;
      in_valid <= 1'b0;
      v_q <= 32'sh0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      in_valid <= run && (cnt_q == 2'h3);
      v_q <= volt_uv;
    end
  end
  // Detector trips above 11 V
  assign ovl_det = (volt_uv > 32'sh00a7d8c0) || (volt_uv < -32'sh00a7d8c0);
  // Lines are junk outside the strobe; the low pair floats while the path is cut
  assign smp_1v = (in_valid && direct_en) ? conv(v_q, 32'sh00124f80, 32'hffffffff) : ~v_q;
  assign smp_10v = (in_valid && direct_en) ? conv(v_q, 32'sh00b71b00, 32'hfffffff0) : ~v_q;
  assign smp_100v = in_valid ? conv(v_q, 32'sh07270e00, 32'hffffff00) : ~v_q;
  assign smp_1000v = in_valid ? (v_q & 32'hfffff000) : ~v_q;
endmodule

// ---- seamless_autorange_blend_control_test.sv ----
/*
  Self-checking bench for the autorange blend controller.
  Assumes the converter model beside it and shortened shutdown and settle counts.
*/
`timescale 1ns/1ps
module seamless_autorange_blend_control_test;
  localparam int SHUT = 8; // Shortened shutdown count
  localparam int SETTLE = 20; // Shortened settle count
  localparam logic [31:0] FS [4] = '{32'hdbba0, 32'h895440, 32'h55d4a80, 32'h35a4e900}; // 90 % of each range
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, e, exp_ok;
  logic in_valid, ovl_det, direct_en, out_valid, out_ok, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [31:0] volt, smp_1v, smp_10v, smp_100v, smp_1000v, out_sample, v, exp_out;
  logic [1:0] chk_on; // Bit 1 compares data, bit 0 the valid flag
  int err_count, n_checks, s, n, m, r, w;
  autorange_ctrl #(.SHUT_CYC(SHUT), .SETTLE_CYC(SETTLE)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .in_valid, .smp_1v, .smp_10v, .smp_100v, .smp_1000v, .ovl_det,
    .direct_en, .out_valid, .out_sample, .out_ok, .irq);
  range_adc_model adc (.pclk, .presetn, .run, .direct_en, .volt_uv(volt), .in_valid, .ovl_det, .smp_1v,
    .smp_10v, .smp_100v, .smp_1000v);
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] expv);
    n_checks++;
    if (got !== expv)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask
  // One APB transfer, held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Run cnt conversions at one input level, then let the pipeline drain
  task burst(input logic signed [31:0] val, input int cnt, input logic [1:0] mode);
    volt <= val;
    run <= 1'b1;
    chk_on <= mode;
    repeat (cnt) do @(posedge pclk); while (in_valid !== 1'b1);
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_on <= 2'h0;
  endtask
  // Cycles until the direct path is back, bounded
  task wait_en(output int cyc);
    cyc = 0;
    while (direct_en !== 1'b1 && cyc < 200)
    begin
      @(posedge pclk);
      cyc++;
    end
  endtask
  // Value a range's converter reports
  function automatic logic [31:0] quant(input logic signed [31:0] x, input int rg);
    return x & ~((32'h1 << (4 * rg)) - 32'h1);
  endfunction
  // Weight after up and down steps, saturating
  function automatic int wexp(input int up, input int dn, input int st);
    int t;
    t = (up * st > 256) ? 256 : up * st;
    t = t - dn * st;
    return (t < 0) ? 0 : t;
  endfunction
  // Random level within fs either side of zero
  function automatic logic signed [31:0] rv(input logic [31:0] fs);
    return $urandom % (2 * fs) - fs;
  endfunction
  // Report counts and verdict
  task end_of_test;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Output stream checks
  always @(posedge pclk)
  begin
    if (out_valid === 1'b1 && chk_on[1])
      chk(out_sample, exp_out);
    if (out_valid === 1'b1 && chk_on[0])
      chk(32'(out_ok), 32'(exp_ok));
  end
  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Run takes under 10 us, so 200 us means a hang
  initial
  begin
    #200000;
    err_count++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, run, exp_ok, chk_on} = 8'h4;
    {paddr, pwdata, volt, exp_out} = '0;
    err_count = 0;
    n_checks = 0;
    s = $urandom(4);
    s = 8 + $urandom % 57;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped address
    apb(1'b0, autorange_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'(autorange_pkg::CTRL_RESET));
    apb(1'b0, autorange_pkg::REG_STEP, 32'h0);
    chk(rd, 32'(autorange_pkg::STEP_RESET));
    apb(1'b0, 8'h1c, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    // Small input comes from the 1 V converter alone
    v = rv(FS[0]);
    exp_out = v;
    burst(v, 4, 2'h3);
    // Ramp into the band at 10.5 V, then back at 0.5 V
    apb(1'b1, autorange_pkg::REG_STEP, 32'(s));
    n = 2 + $urandom % 39;
    m = 1 + $urandom % n;
    burst(32'sh00a037a0, n, 2'h0);
    apb(1'b0, autorange_pkg::REG_WEIGHT, 32'h0);
    w = wexp(n, 0, s);
    chk(rd, 32'((w << 10) | w));
    burst(32'sh0007a120, m, 2'h0);
    apb(1'b0, autorange_pkg::REG_WEIGHT, 32'h0);
    w = wexp(n, m, s);
    chk(rd, 32'((w << 10) | w));
    // Overload at 50 V, then one 10.8 V excursion during the settle wait
    apb(1'b1, autorange_pkg::REG_IRQ_EN, 32'h3);
    volt <= 32'sh02faf080;
    repeat (2) @(posedge pclk);
    chk(32'(direct_en), 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b0, autorange_pkg::REG_STATUS, 32'h0);
    chk(32'(rd[2:1]), 32'(autorange_pkg::DP_SHUT));
    repeat (2 * SHUT) @(posedge pclk);
    volt <= 32'sh004c4b40;
    run <= 1'b1;
    repeat (10) @(posedge pclk);
    volt <= 32'sh00a4cb80;
    repeat (4) @(posedge pclk);
    volt <= 32'sh004c4b40;
    wait_en(n);
    run <= 1'b0;
    chk(32'(n > 14 && n <= SETTLE + 4), 32'h1);
    apb(1'b0, autorange_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, autorange_pkg::REG_IRQ_CLR, 32'h3);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    // Every manual range uses its own converter only
    for (r = 0; r < 4; r++)
    begin
      apb(1'b1, autorange_pkg::REG_CTRL, 32'(r << 1));
      v = rv(FS[r]);
      exp_out = quant(v, r);
      burst(v, 3, 2'h3);
      chk(32'(direct_en), 32'(r < 2));
    end
    // Auto mode at 500 V settles on the 1000 V converter
    apb(1'b1, autorange_pkg::REG_CTRL, 32'h1);
    burst(32'sh1dcd6500, 40, 2'h0);
    exp_out = quant(32'sh1dcd6500, 3);
    burst(32'sh1dcd6500, 4, 2'h3);
    // Manual 10 V overload: path cut, data invalid until settled
    apb(1'b1, autorange_pkg::REG_CTRL, 32'h2);
    exp_ok = 1'b0;
    burst(32'sh01312d00, 2, 2'h0);
    burst(32'sh01312d00, 6, 2'h1);
    chk(32'(direct_en), 32'h0);
    volt <= 32'sh004c4b40;
    wait_en(n);
    chk(32'(n >= SETTLE - 2 && n <= SETTLE + 4), 32'h1);
    apb(1'b0, autorange_pkg::REG_IRQ_STAT, 32'h0);
    chk(32'(rd[2]), 32'h1);
    // Path restore event is enabled, so the line is up until cleared
    chk(32'(irq), 32'h1);
    apb(1'b1, autorange_pkg::REG_IRQ_CLR, 32'h3);
    @(posedge pclk);
    // Only the disabled invalid-sample event is left pending
    chk(32'(irq), 32'h0);
    exp_ok = 1'b1;
    exp_out = quant(32'sh004c4b40, 1);
    burst(32'sh004c4b40, 3, 2'h3);
    chk(32'(direct_en), 32'h1);
    end_of_test;
  end
endmodule
